// *** apc_pkg.sv ***
// Package for the audio port pin configuration register bank.
// Assumes an APB master with 32-bit data and one register per aligned word.
// How it works
// (RULE1) PDM input-pin source overridden to serial input
// (RULE2) Shared bit makes output pin bidirectional
// (RULE3) Record power-down pin select encoding
// (RULE4) Record powerdown is pin OR register
// (RULE5) Playback power-down pin select encoding
// (RULE6) Playback powerdown is pin OR register
// (RULE7) Mic bias enable pin select
// (RULE8) Aux converter start pin select
// (RULE9) Reserved bits read zero, writes ignored
// (RULE10) Primary port disable bit, resets enabled
// (RULE11) Secondary port disable resets to one
// (RULE12) Gang bit copies primary settings to secondary
// (RULE13) Daisy mode field selects chained port
// (RULE14) Daisy chaining leaves one port only
// (RULE15) Daisy input source select encoding
// (RULE16) Software never writes daisy mode three
// (RULE17) PDM pair select encoding
// (RULE18) Pin controls synchronised before use
package apc_pkg;
  // Printed offsets are not all multiples of four: these are indices
  localparam logic [7:0] APC_IDX_PIN_A = 8'h14;
  localparam logic [7:0] APC_IDX_PIN_B = 8'h15;
  localparam logic [7:0] APC_IDX_SPORT = 8'h18;
  localparam logic [7:0] APC_IDX_CTRL = 8'h1C;
  localparam logic [7:0] APC_IDX_STAT = 8'h1D;
  localparam logic [7:0] APC_IDX_PDM = 8'h1E;
  localparam int APC_AW = 10;
  localparam logic [7:0] APC_RST_PIN_A = 8'h00;
  localparam logic [7:0] APC_RST_PIN_B = 8'h00;
  localparam logic [7:0] APC_RST_SPORT = 8'h40;
  localparam logic [7:0] APC_RST_CTRL = 8'h00;
  localparam logic [7:0] APC_RST_PDM = 8'h00;
  localparam logic [7:0] APC_MASK_PIN_A = 8'hFC;
  localparam logic [7:0] APC_MASK_PIN_B = 8'hF0;
  localparam logic [7:0] APC_MASK_SPORT = 8'hFF;
  localparam logic [7:0] APC_MASK_CTRL = 8'h03;
  localparam logic [7:0] APC_MASK_PDM = 8'h0F;
  // Field positions
  localparam int APC_B_OVRD = 7;
  localparam int APC_B_SHARED = 6;
  localparam int APC_F_RECPD = 4;
  localparam int APC_F_PLAYPD = 2;
  localparam int APC_F_MBIAS = 6;
  localparam int APC_F_AUXST = 4;
  localparam int APC_B_PDIS = 7;
  localparam int APC_B_SDIS = 6;
  localparam int APC_B_GANG = 5;
  localparam int APC_F_DAISY = 3;
  localparam int APC_F_DIN = 0;
  localparam int APC_F_PDMA = 2;
  localparam int APC_F_PDMB = 0;
  localparam int APC_SYNC_STAGES = 2;
  // Pin select codes
  localparam logic [1:0] APC_SEL_OFF = 2'h0;
  localparam logic [1:0] APC_SEL_GP1 = 2'h1;
  localparam logic [1:0] APC_SEL_GP2 = 2'h2;
  localparam logic [1:0] APC_SEL_GPI = 2'h3;
  localparam logic [2:0] APC_DIN_SERIAL = 3'h5;
  localparam logic [1:0] APC_DAISY_OFF = 2'h0;
  localparam logic [1:0] APC_DAISY_PRI = 2'h1;
  localparam logic [1:0] APC_DAISY_SEC = 2'h2;
  typedef enum logic [1:0] {APC_ST_IDLE, APC_ST_ACCESS} apc_bus_st_t;
endpackage : apc_pkg

// *** apc_pin_if.sv ***
// Interface carrying synchronised general pins between top and pin sync.
// Assumes one clock domain.
`timescale 1ns/100ps
`default_nettype none
interface apc_pin_if #(
  parameter int WIDTH = 3
);
  logic [WIDTH-1:0] pins;
  modport src (output pins);
  modport dst (input pins);
endinterface : apc_pin_if
`default_nettype wire

// *** apc_pin_sync.sv ***
// Two-stage synchroniser for the general pins and serial input pin.
// Assumes pins are asynchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
module apc_pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw pins
  input wire logic [WIDTH-1:0] raw,
  // Synchronised pins
  apc_pin_if.src out
);
  import apc_pkg::*;
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } apc_sync_t;
  apc_sync_t st_q, st_d;
  always_comb begin
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d; // [RULE18]
    end
  end
  assign out.pins = st_q.s2;
endmodule : apc_pin_sync
`default_nettype wire

// *** apc_pin_mux.sv ***
// Picks one of the synchronised general pins by a two-bit select.
// Assumes select codes: off, pin one, pin two, input pin.
`timescale 1ns/100ps
`default_nettype none
module apc_pin_mux (
  // Select and pins
  input wire logic [1:0] sel,
  apc_pin_if.dst pins,
  // Result
  output logic hit
);
  import apc_pkg::*;
  always_comb begin
    case (sel)
      APC_SEL_GP1: hit = pins.pins[0];
      APC_SEL_GP2: hit = pins.pins[1];
      APC_SEL_GPI: hit = pins.pins[2];
      default: hit = 1'b0;
    endcase
  end
endmodule : apc_pin_mux
`default_nettype wire

// *** apc_regs.sv ***
// Audio port pin configuration register bank, APB slave.
// Assumes APB3 master; pins asynchronous; single clock pclk.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module apc_regs (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [apc_pkg::APC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device pins
  input wire logic gpio_one_in,
  input wire logic gpio_two_in,
  input wire logic gpin_in,
  input wire logic serial_din_in,
  // Control outputs
  output logic record_conv_pd,
  output logic playback_conv_pd,
  output logic mic_bias_en,
  output logic aux_conv_start,
  output logic primary_port_en,
  output logic secondary_port_en,
  output logic secondary_gang,
  output logic [1:0] daisy_mode,
  output logic daisy_in,
  output logic dout_shared,
  output logic pdm_pair_a_data,
  output logic pdm_pair_b_data
);
  import apc_pkg::*;

  typedef struct packed {
    apc_bus_st_t bus;
    logic [7:0] pin_a;
    logic [7:0] pin_b;
    logic [7:0] sport;
    logic [7:0] ctrl;
    logic [7:0] pdm;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic rec_pd;
    logic play_pd;
    logic mbias;
    logic aux_st;
    logic aux_prev;
    logic p_en;
    logic s_en;
    logic gang;
    logic [1:0] daisy;
    logic din;
    logic shared;
    logic pdm_a;
    logic pdm_b;
  } apc_state_t;

  apc_state_t st_q, st_d;

  apc_pin_if gp ();
  apc_pin_if #(.WIDTH(1)) sd ();
  logic rec_hit, play_hit, mb_hit, aux_hit, pa_hit, pb_hit;

  apc_pin_sync #(.WIDTH(3)) u_gp_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw({gpin_in, gpio_two_in, gpio_one_in}),
    .out(gp)
  );
  apc_pin_sync #(.WIDTH(1)) u_sd_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw(serial_din_in),
    .out(sd)
  );

  apc_pin_mux u_rec (.sel(st_q.pin_a[APC_F_RECPD +: 2]), .pins(gp), .hit(rec_hit)); // [RULE3]
  apc_pin_mux u_play (.sel(st_q.pin_a[APC_F_PLAYPD +: 2]), .pins(gp), .hit(play_hit)); // [RULE5]
  apc_pin_mux u_mb (.sel(st_q.pin_b[APC_F_MBIAS +: 2]), .pins(gp), .hit(mb_hit)); // [RULE7]
  apc_pin_mux u_aux (.sel(st_q.pin_b[APC_F_AUXST +: 2]), .pins(gp), .hit(aux_hit)); // [RULE8]
  apc_pin_mux u_pa (.sel(st_q.pdm[APC_F_PDMA +: 2]), .pins(gp), .hit(pa_hit)); // [RULE17]
  apc_pin_mux u_pb (.sel(st_q.pdm[APC_F_PDMB +: 2]), .pins(gp), .hit(pb_hit)); // [RULE17]

  // Register index from byte address
  function automatic logic [7:0] reg_idx(input logic [APC_AW-1:0] a);
    reg_idx = a[APC_AW-1:2];
  endfunction : reg_idx

  // Known register index
  function automatic logic mapped(input logic [7:0] i);
    mapped = (i == APC_IDX_PIN_A) || (i == APC_IDX_PIN_B) || (i == APC_IDX_SPORT) ||
             (i == APC_IDX_CTRL) || (i == APC_IDX_STAT) || (i == APC_IDX_PDM);
  endfunction : mapped

  // Write-protected registers (status only); reserved bits are masked on write
  function automatic logic writable(input logic [7:0] i);
    writable = (i != APC_IDX_STAT);
  endfunction : writable

  function automatic logic pdm_src(input logic [1:0] sel, input logic hit, input logic ovrd,
                                   input logic din);
    if (ovrd && (sel == APC_SEL_GPI)) begin
      pdm_src = din;
    end else begin
      pdm_src = hit;
    end
  endfunction : pdm_src

  logic [7:0] idx;
  logic [7:0] status;
  logic reg_rec_pd, reg_play_pd;
  logic [2:0] din_sel;
  logic [1:0] dmode;

  assign idx = reg_idx(paddr);
  assign reg_rec_pd = st_q.ctrl[0];
  assign reg_play_pd = st_q.ctrl[1];
  assign din_sel = st_q.sport[APC_F_DIN +: 3];
  assign dmode = st_q.sport[APC_F_DAISY +: 2];
  assign status = {st_q.shared, st_q.din, st_q.aux_st, st_q.mbias, st_q.play_pd,
                   st_q.rec_pd, st_q.s_en, st_q.p_en};

  always_comb begin
    st_d = st_q;
    st_d.ready = 1'b0;
    st_d.err = 1'b0;
    // APB access: no wait state, answer in access phase
    case (st_q.bus)
      APC_ST_IDLE: begin
        if (psel && !penable) begin
          st_d.bus = APC_ST_ACCESS;
          st_d.ready = 1'b1;
          st_d.err = !mapped(idx) || (pwrite && !writable(idx));
          st_d.rdata = 32'h0000_0000;
          if (!pwrite) begin
            case (idx)
              APC_IDX_PIN_A: st_d.rdata[7:0] = st_q.pin_a; // [RULE9]
              APC_IDX_PIN_B: st_d.rdata[7:0] = st_q.pin_b; // [RULE9]
              APC_IDX_SPORT: st_d.rdata[7:0] = st_q.sport;
              APC_IDX_CTRL: st_d.rdata[7:0] = st_q.ctrl;
              APC_IDX_STAT: st_d.rdata[7:0] = status;
              APC_IDX_PDM: st_d.rdata[7:0] = st_q.pdm;
              default: st_d.rdata = 32'h0000_0000;
            endcase
          end
        end
      end
      APC_ST_ACCESS: begin
        st_d.bus = APC_ST_IDLE;
        if (psel && penable && pwrite) begin
          case (idx)
            APC_IDX_PIN_A: st_d.pin_a = pwdata[7:0] & APC_MASK_PIN_A; // [RULE9]
            APC_IDX_PIN_B: st_d.pin_b = pwdata[7:0] & APC_MASK_PIN_B; // [RULE9]
            APC_IDX_SPORT: st_d.sport = pwdata[7:0] & APC_MASK_SPORT;
            APC_IDX_CTRL: st_d.ctrl = pwdata[7:0] & APC_MASK_CTRL;
            APC_IDX_PDM: st_d.pdm = pwdata[7:0] & APC_MASK_PDM;
            default: st_d.pdm = st_q.pdm;
          endcase
        end
      end
      default: st_d.bus = APC_ST_IDLE;
    endcase

    // Control outputs from current configuration
    st_d.rec_pd = rec_hit | reg_rec_pd; // [RULE4]
    st_d.play_pd = play_hit | reg_play_pd; // [RULE6]
    st_d.mbias = mb_hit;
    st_d.aux_prev = aux_hit;
    st_d.aux_st = aux_hit & ~st_q.aux_prev;
    st_d.shared = st_q.pin_a[APC_B_SHARED]; // [RULE2]
    st_d.gang = st_q.sport[APC_B_GANG]; // [RULE12]
    st_d.daisy = dmode;
    // Daisy mode leaves only the chained port available
    case (dmode)
      APC_DAISY_PRI: begin
        st_d.p_en = ~st_q.sport[APC_B_PDIS]; // [RULE14]
        st_d.s_en = 1'b0; // [RULE13]
      end
      APC_DAISY_SEC: begin
        st_d.p_en = 1'b0; // [RULE13]
        st_d.s_en = ~st_q.sport[APC_B_SDIS]; // [RULE14]
      end
      default: begin
        st_d.p_en = ~st_q.sport[APC_B_PDIS]; // [RULE10]
        st_d.s_en = ~st_q.sport[APC_B_SDIS]; // [RULE11]
      end
    endcase
    // Daisy input source
    case (din_sel)
      3'h1: st_d.din = gp.pins[0]; // [RULE15]
      3'h2: st_d.din = gp.pins[1];
      3'h3: st_d.din = gp.pins[2];
      APC_DIN_SERIAL: st_d.din = sd.pins[0];
      default: st_d.din = 1'b0;
    endcase
    if (dmode == APC_DAISY_OFF) begin
      st_d.din = 1'b0;
    end
    st_d.pdm_a = pdm_src(st_q.pdm[APC_F_PDMA +: 2], pa_hit, st_q.pin_a[APC_B_OVRD], sd.pins[0]); // [RULE1]
    st_d.pdm_b = pdm_src(st_q.pdm[APC_F_PDMB +: 2], pb_hit, st_q.pin_a[APC_B_OVRD], sd.pins[0]); // [RULE1]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.bus <= APC_ST_IDLE;
      st_q.pin_a <= APC_RST_PIN_A;
      st_q.pin_b <= APC_RST_PIN_B;
      st_q.sport <= APC_RST_SPORT; // [RULE11]
      st_q.ctrl <= APC_RST_CTRL;
      st_q.pdm <= APC_RST_PDM;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.err;
  assign record_conv_pd = st_q.rec_pd;
  assign playback_conv_pd = st_q.play_pd;
  assign mic_bias_en = st_q.mbias;
  assign aux_conv_start = st_q.aux_st;
  assign primary_port_en = st_q.p_en;
  assign secondary_port_en = st_q.s_en;
  assign secondary_gang = st_q.gang;
  assign daisy_mode = st_q.daisy;
  assign daisy_in = st_q.din;
  assign dout_shared = st_q.shared;
  assign pdm_pair_a_data = st_q.pdm_a;
  assign pdm_pair_b_data = st_q.pdm_b;
endmodule : apc_regs
`default_nettype wire

// *** apc_regs_props.sv ***
// Checker for the pin configuration register bank, bound to apc_regs.
// Assumes one clock pclk and the asynchronous active-low reset presetn.
`timescale 1ns/100ps
`default_nettype none
module apc_regs_props (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [apc_pkg::APC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins
  input wire logic gpio_one_in,
  input wire logic gpio_two_in,
  input wire logic gpin_in,
  // Controls
  input wire logic record_conv_pd,
  input wire logic playback_conv_pd,
  input wire logic mic_bias_en,
  input wire logic aux_conv_start,
  input wire logic primary_port_en,
  input wire logic secondary_port_en,
  input wire logic secondary_gang,
  input wire logic [1:0] daisy_mode
);
  import apc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write committed to one register
  sequence s_wr(logic [7:0] idx);
    psel && penable && pready && pwrite && paddr[9:2] == idx;
  endsequence
  a_resv_read: assert property (pready && !pwrite && paddr[9:2] == APC_IDX_PIN_B |-> prdata[3:0] == 4'h0)
    else $error("reserved bits read nonzero");
  a_rec_reg_pd: assert property (s_wr(APC_IDX_CTRL) ##0 pwdata[0] |-> ##[1:2] record_conv_pd)
    else $error("record power-down not set");
  a_play_reg_pd: assert property (s_wr(APC_IDX_CTRL) ##0 pwdata[1] |-> ##[1:2] playback_conv_pd)
    else $error("playback power-down not set");
  a_pri_disable: assert property (s_wr(APC_IDX_SPORT) ##0 pwdata[7] |-> ##[1:2] !primary_port_en)
    else $error("primary port not disabled");
  a_gang_follow: assert property (s_wr(APC_IDX_SPORT) ##0 pwdata[5] |-> ##[1:2] secondary_gang)
    else $error("gang bit not followed");
  a_pri_daisy: assert property (daisy_mode == 2'h2 [*3] |-> !primary_port_en)
    else $error("primary port on in secondary chain");
  a_one_port: assert property ((daisy_mode == 2'h1 || daisy_mode == 2'h2) [*3] |->
    !(primary_port_en && secondary_port_en))
    else $error("two ports while chaining");
  a_aux_pulse: assert property (aux_conv_start |=> !aux_conv_start)
    else $error("start pulse too long");
  a_bias_sync: assert property ($rose(mic_bias_en) |->
    $past(gpio_one_in, 3) || $past(gpio_two_in, 3) || $past(gpin_in, 3))
    else $error("bias enable ahead of synchroniser");
endmodule : apc_regs_props
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the pin configuration register bank.
// Assumes zero-wait APB answers and a three-edge pin latency.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import apc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [APC_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic gpio_one_in, gpio_two_in, gpin_in, serial_din_in, record_conv_pd, playback_conv_pd, mic_bias_en;
  logic aux_conv_start, primary_port_en, secondary_port_en, secondary_gang, daisy_in, dout_shared;
  logic pdm_pair_a_data, pdm_pair_b_data;
  logic [1:0] daisy_mode;
  logic [31:0] seed = 32'h0000004A;
  int num_errors = 0;
  int total_checks = 0;
  apc_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .gpio_one_in, .gpio_two_in, .gpin_in, .serial_din_in, .record_conv_pd, .playback_conv_pd, .mic_bias_en,
    .aux_conv_start, .primary_port_en, .secondary_port_en, .secondary_gang, .daisy_mode, .daisy_in,
    .dout_shared, .pdm_pair_a_data, .pdm_pair_b_data);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic pick(input logic [1:0] s, input logic ovr);
    logic [3:0] p;
    p = {gpin_in, gpio_two_in, gpio_one_in, 1'b0};
    return (ovr && s == 2'h3) ? serial_din_in : p[s];
  endfunction : pick
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk("read", rd, {24'h000000, exp});
  endtask : rchk
  task automatic rpins();
    logic [31:0] r;
    r = xs();
    {gpio_one_in, gpio_two_in, gpin_in, serial_din_in} <= r[3:0];
    repeat (4) @(posedge pclk);
  endtask : rpins
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_of_test();
  end
  initial begin
    int s, k;
    logic [31:0] g;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {gpio_one_in, gpio_two_in, gpin_in, serial_din_in} = 4'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(APC_IDX_PIN_B, 8'h00);
    rchk(APC_IDX_SPORT, 8'h40);
    chk("p_en", primary_port_en, 1'b1);
    chk("s_en", secondary_port_en, 1'b0);
    rchk(APC_IDX_STAT, 8'h01);
    apb(1'b1, APC_IDX_STAT, 8'hFF);
    chk("ro_write", err, 1'b1);
    apb(1'b0, 8'h00, 8'h00);
    chk("unmapped", err, 1'b1);
    apb(1'b1, APC_IDX_PIN_B, 8'hFF);
    rchk(APC_IDX_PIN_B, 8'hF0);
    $display("test reset done");
    for (s = 0; s < 4; s++) begin
      apb(1'b1, APC_IDX_PIN_A, {2'h0, s[1:0], ~s[1:0], 2'h0});
      apb(1'b1, APC_IDX_PIN_B, {s[1:0], 6'h00});
      for (k = 0; k < 4; k++) begin
        apb(1'b1, APC_IDX_CTRL, {6'h00, k[1:0]});
        rpins();
        chk("rec_pd", record_conv_pd, k[0] | pick(s[1:0], 1'b0));
        chk("play_pd", playback_conv_pd, k[1] | pick(~s[1:0], 1'b0));
        chk("bias", mic_bias_en, pick(s[1:0], 1'b0));
      end
      apb(1'b1, APC_IDX_PIN_B, {2'h0, s[1:0], 4'h0});
      {gpio_one_in, gpio_two_in, gpin_in} <= 3'h0;
      repeat (4) @(posedge pclk);
      {gpio_one_in, gpio_two_in, gpin_in} <= 3'h7;
      k = 0;
      repeat (6) begin
        @(posedge pclk);
        if (aux_conv_start === 1'b1) k++;
      end
      chk("aux_pulses", k, s != 0);
    end
    $display("test pin select done");
    for (s = 0; s < 12; s++) begin
      g = xs();
      apb(1'b1, APC_IDX_SPORT, {s[1:0], g[0], s[3:2], 3'h0});
      repeat (3) @(posedge pclk);
      chk("p_en", primary_port_en, !s[1] && s[3:2] != 2'h2);
      chk("s_en", secondary_port_en, !s[0] && s[3:2] != 2'h1);
      chk("gang", secondary_gang, g[0]);
      chk("mode", daisy_mode, s[3:2]);
    end
    for (s = 0; s < 16; s++) begin
      apb(1'b1, APC_IDX_SPORT, {5'h01, s[2:0]});
      rpins();
      chk("daisy_in", daisy_in, s[2:0] == 3'h5 ? serial_din_in : (s[2] ? 1'b0 : pick(s[1:0], 1'b0)));
      apb(1'b1, APC_IDX_PIN_A, {s[3], s[3], 6'h00});
      apb(1'b1, APC_IDX_PDM, {4'h0, s[1:0], s[2:1]});
      rpins();
      chk("shared", dout_shared, s[3]);
      chk("pdm_a", pdm_pair_a_data, pick(s[1:0], s[3]));
      chk("pdm_b", pdm_pair_b_data, pick(s[2:1], s[3]));
    end
    $display("test serial port done");
    end_of_test();
  end
endmodule : tb
bind apc_regs apc_regs_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .gpio_one_in, .gpio_two_in, .gpin_in, .record_conv_pd, .playback_conv_pd, .mic_bias_en,
  .aux_conv_start, .primary_port_en, .secondary_port_en, .secondary_gang, .daisy_mode);
`default_nettype wire
